/* File: design/fcl_pkg.sv */
// Purpose: Shared constants and types for the flash command launch control block.
// Assumes: 32-bit APB data, each register in one aligned word.
// Notes:   Command codes, register offsets and field positions live here only.
package fcl_pkg;

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] OFS_TIME_BASE_DIVIDER  = 8'h00;
  localparam logic [7:0] OFS_CONTROLLER_STATUS  = 8'h04;
  localparam logic [7:0] OFS_PARAMETER_INDEX    = 8'h08;
  localparam logic [7:0] OFS_PARAMETER_ARRAY    = 8'h0c;
  localparam logic [7:0] OFS_PROGRAM_PROTECT    = 8'h10;
  localparam logic [7:0] OFS_DATA_PROTECT       = 8'h14;
  localparam logic [7:0] OFS_FACTORY_RESERVED7  = 8'h18;
  localparam logic [7:0] OFS_VERSION_ID         = 8'h1c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          DIVIDER_LOADED_BIT = 7;
  localparam int          DIVIDER_WIDTH      = 7;
  localparam int          STATUS_COMMAND_COMPLETE_FLAG_BIT    = 7;
  localparam int          STATUS_ACCESS_ERROR_FLAG_BIT  = 5;
  localparam int          STATUS_PVIOL_BIT   = 4;
  localparam int          PROT_LOW_DIS_BIT   = 5;
  localparam int          PROT_HIGH_DIS_BIT  = 6;
  localparam int          PROT_OPEN_BIT      = 7;
  localparam int          DATA_OPEN_BIT      = 7;
  localparam int          INDEX_WIDTH        = 3;
  localparam int          NUM_WORDS          = 6;
  localparam logic [7:0]  PROTECT_RESET      = 8'hff;
  localparam logic [15:0] WORD_ZERO          = 16'h0000;
  localparam int          CODE_WORD          = 0;
  localparam int          CODE_MSB           = 15;
  localparam int          CODE_LSB           = 8;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_ERASE_VERIFY_ALL   = 8'h01;
  localparam logic [7:0] CMD_ERASE_VERIFY_BLOCK = 8'h02;
  localparam logic [7:0] CMD_ERASE_VERIFY_PSECT = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE          = 8'h04;
  localparam logic [7:0] CMD_PROGRAM_PHRASE     = 8'h06;
  localparam logic [7:0] CMD_PROGRAM_ONCE       = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL          = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK        = 8'h09;
  localparam logic [7:0] CMD_ERASE_PSECTOR      = 8'h0a;
  localparam logic [7:0] CMD_UNSECURE           = 8'h0b;
  localparam logic [7:0] CMD_VERIFY_KEY         = 8'h0c;
  localparam logic [7:0] CMD_USER_MARGIN        = 8'h0d;
  localparam logic [7:0] CMD_FIELD_MARGIN       = 8'h0e;
  localparam logic [7:0] CMD_ERASE_VERIFY_DSECT = 8'h10;
  localparam logic [7:0] CMD_PROGRAM_DATA       = 8'h11;
  localparam logic [7:0] CMD_ERASE_DSECTOR      = 8'h12;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [15:0] fcl_word_t;

  // Parameter array handed to the memory controller; word 0 high byte is the code.
  typedef struct packed {
    fcl_word_t [NUM_WORDS-1:0] words;
  } fcl_params_t;

  // Version identification word: upper bits reserved, low nibble is the version.
  typedef struct packed {
    logic [11:0] reserved;
    logic [3:0]  version_number_field;
  } fcl_version_t;

  typedef enum logic [0:0] {
    FCL_IDLE = 1'b0,
    FCL_BUSY = 1'b1
  } fcl_state_t;

endpackage

/* File: design/fcl_top.sv */
// Purpose: APB register front end that loads, checks and launches flash commands.
// Assumes: Memory controller back end reports completion with a one-cycle done pulse.
// Notes:   Mode and security pins are asynchronous and pass a three-stage filter.
// Notes on behaviour
// - Mode pin: low normal, high special mode.
// - Version word: reserved upper, low nibble version.
// - Divider write sets divider loaded bit, except in normal mode while busy.
// - Unloaded divider: program/erase refused, access error.
// - Busy: no new launch, array writes ignored.
// - Index register selects parameter array word.
// - Writing one to complete flag launches.
// - Flag stays clear until done; results readable.
// - Erase-all, unsecure only in special mode.
// - Backdoor key verify only in normal mode.
// - Field margin only unsecured special mode.
// - Secured special mode allows four commands.
// - Read-once returns the one-time field.
// - Program-once writes one-time field once.
// - Program command writes one phrase.
// - Erase-all needs all protection open bits.
// - Block erase needs program protection open.
// - Section verify and sector erase forwarded.
// - Command code in high byte word zero.
// - Invalid command sets access error, not run.
`timescale 1ns/10ps

module fcl_top #(
  parameter logic [3:0] VERSION_NUMBER = 4'h3  // Arbitrary value.
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 special_mode_input,
  input  wire logic                 secured_input,
  output logic                      launch_pulse,
  output fcl_pkg::fcl_params_t      launch_params,
  output logic      [6:0]           divider_value_field,
  input  wire logic                 mc_done,
  input  wire logic                 mc_protection_violation,
  input  wire fcl_pkg::fcl_params_t mc_results
);
  import fcl_pkg::*;

  // ****************************************************************
  // Reset release and pin filtering
  // ****************************************************************
  logic       rst_s1_q;
  logic       rst_s2_q;
  logic       rst_n;
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_val_q;
  logic [1:0] pin_val_d;
  logic       special_mode;
  logic       secured;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n   = rst_s2_q;
  assign pin_raw = {secured_input, special_mode_input};

  // A glitch on a mode pin must not flip the legal command set for a cycle.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_comb begin
        pin_val_d[gi] = pin_val_q[gi];
        if (pin_s2_q[gi] == pin_s3_q[gi]) begin
          pin_val_d[gi] = pin_s3_q[gi];
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_q[gi]  <= 1'b0;
          pin_s2_q[gi]  <= 1'b0;
          pin_s3_q[gi]  <= 1'b0;
          pin_val_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi]  <= pin_raw[gi];
          pin_s2_q[gi]  <= pin_s1_q[gi];
          pin_s3_q[gi]  <= pin_s2_q[gi];
          pin_val_q[gi] <= pin_val_d[gi];
        end
      end
    end
  endgenerate
  assign special_mode = pin_val_q[0];
  assign secured      = pin_val_q[1];

  // ****************************************************************
  // Command legality
  // ****************************************************************
  function automatic logic cmd_legal(input logic [7:0] code, input logic spc, input logic sec);
    logic ok;
    ok = 1'b0;
    unique case (code)
      CMD_ERASE_VERIFY_ALL, CMD_ERASE_VERIFY_BLOCK: ok = 1'b1;
      CMD_ERASE_ALL, CMD_UNSECURE:                  ok = spc;
      CMD_VERIFY_KEY:                               ok = !spc;
      CMD_FIELD_MARGIN:                             ok = spc && !sec;
      CMD_ERASE_VERIFY_PSECT, CMD_READ_ONCE, CMD_PROGRAM_PHRASE, CMD_PROGRAM_ONCE,
      CMD_ERASE_BLOCK, CMD_ERASE_PSECTOR, CMD_USER_MARGIN, CMD_ERASE_VERIFY_DSECT,
      CMD_PROGRAM_DATA, CMD_ERASE_DSECTOR:          ok = !(spc && sec);
      default:                                      ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic cmd_alters(input logic [7:0] code);
    logic alt;
    alt = 1'b0;
    unique case (code)
      CMD_PROGRAM_PHRASE, CMD_PROGRAM_ONCE, CMD_ERASE_ALL, CMD_ERASE_BLOCK,
      CMD_ERASE_PSECTOR, CMD_UNSECURE, CMD_PROGRAM_DATA, CMD_ERASE_DSECTOR: alt = 1'b1;
      default: alt = 1'b0;
    endcase
    return alt;
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  fcl_state_t                 state_q,    state_d;
  logic [DIVIDER_WIDTH-1:0]   div_q,      div_d;
  logic                       div_ld_q,   div_ld_d;
  logic                       access_error_flag_q,   access_error_flag_d;
  logic                       pviol_q,    pviol_d;
  logic [INDEX_WIDTH-1:0]     index_q,    index_d;
  logic [7:0]                 pprot_q,    pprot_d;
  logic [7:0]                 dprot_q,    dprot_d;
  fcl_word_t [NUM_WORDS-1:0]  arr_q,      arr_d;
  logic                       launch_q,   launch_d;
  fcl_params_t                lparams_q,  lparams_d;
  logic [31:0]                rdata_q,    rdata_d;

  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic        command_complete_flag;
  logic [7:0]  code;
  logic        legal;
  logic        prot_ok;
  fcl_word_t   cur_word;
  fcl_version_t version_word;
  logic [31:0] status_word;
  logic [31:0] divider_word;

  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign command_complete_flag     = (state_q == FCL_IDLE);
  assign code     = arr_q[CODE_WORD][CODE_MSB:CODE_LSB];
  assign legal    = cmd_legal(code, special_mode, secured);
  assign cur_word = (index_q < INDEX_WIDTH'(NUM_WORDS)) ? arr_q[index_q] : WORD_ZERO;
  assign version_word = '{reserved: '0, version_number_field: VERSION_NUMBER};

  // Read words are assembled from the field positions so the map lives in one place.
  always_comb begin
    status_word                      = 32'h00000000;
    status_word[STATUS_COMMAND_COMPLETE_FLAG_BIT]     = command_complete_flag;
    status_word[STATUS_ACCESS_ERROR_FLAG_BIT]   = access_error_flag_q;
    status_word[STATUS_PVIOL_BIT]    = pviol_q;
    divider_word                     = 32'h00000000;
    divider_word[DIVIDER_WIDTH-1:0]  = div_q;
    divider_word[DIVIDER_LOADED_BIT] = div_ld_q;
  end

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      OFS_TIME_BASE_DIVIDER, OFS_CONTROLLER_STATUS, OFS_PARAMETER_INDEX, OFS_PARAMETER_ARRAY,
      OFS_PROGRAM_PROTECT, OFS_DATA_PROTECT, OFS_FACTORY_RESERVED7, OFS_VERSION_ID: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    prot_ok = 1'b1;
    if (code == CMD_ERASE_ALL) begin
      prot_ok = pprot_q[PROT_LOW_DIS_BIT] && pprot_q[PROT_HIGH_DIS_BIT] &&
                pprot_q[PROT_OPEN_BIT] && dprot_q[DATA_OPEN_BIT];
    end else if (code == CMD_ERASE_BLOCK) begin
      prot_ok = pprot_q[PROT_LOW_DIS_BIT] && pprot_q[PROT_HIGH_DIS_BIT] &&
                pprot_q[PROT_OPEN_BIT];
    end
  end

  always_comb begin
    state_d   = state_q;
    div_d     = div_q;
    div_ld_d  = div_ld_q;
    access_error_flag_d  = access_error_flag_q;
    pviol_d   = pviol_q;
    index_d   = index_q;
    pprot_d   = pprot_q;
    dprot_d   = dprot_q;
    arr_d     = arr_q;
    launch_d  = 1'b0;
    lparams_d = lparams_q;
    rdata_d   = rdata_q;

    if (wr_en && pstrb[0]) begin
      unique case (paddr)
        OFS_TIME_BASE_DIVIDER: begin
          // Normal mode locks the divider while a command runs so the time base holds.
          if (special_mode || command_complete_flag) begin
            div_d    = pwdata[DIVIDER_WIDTH-1:0];
            div_ld_d = 1'b1;
          end
        end
        OFS_CONTROLLER_STATUS: begin
          if (pwdata[STATUS_ACCESS_ERROR_FLAG_BIT]) begin
            access_error_flag_d = 1'b0;
          end
          if (pwdata[STATUS_PVIOL_BIT]) begin
            pviol_d = 1'b0;
          end
          // Flags are tested before this write's clears, so clear and launch together fail.
          if (pwdata[STATUS_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag && !access_error_flag_q && !pviol_q) begin
            if (!legal) begin
              access_error_flag_d = 1'b1;
            end else if (cmd_alters(code) && !div_ld_q) begin
              access_error_flag_d = 1'b1;
            end else if (!prot_ok) begin
              pviol_d = 1'b1;
            end else begin
              // Read-once, program-once, phrase program, verify and erase run in the back end.
              state_d   = FCL_BUSY;
              launch_d  = 1'b1;
              lparams_d = fcl_params_t'(arr_q);
            end
          end
        end
        OFS_PARAMETER_INDEX: begin
          index_d = pwdata[INDEX_WIDTH-1:0];
        end
        OFS_PROGRAM_PROTECT: begin
          // Normal mode may only tighten protection; special mode may also open it.
          pprot_d = special_mode ? pwdata[7:0] : (pprot_q & pwdata[7:0]);
        end
        OFS_DATA_PROTECT: begin
          dprot_d = special_mode ? pwdata[7:0] : (dprot_q & pwdata[7:0]);
        end
        default: begin
        end
      endcase
    end

    // Array byte lanes: lane 0 low byte, lane 1 high byte; locked while busy.
    if (wr_en && (paddr == OFS_PARAMETER_ARRAY) && command_complete_flag &&
        (index_q < INDEX_WIDTH'(NUM_WORDS))) begin
      if (pstrb[0]) begin
        arr_d[index_q][7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        arr_d[index_q][15:8] = pwdata[15:8];
      end
    end

    // Completion and back-end errors set flags after any software clear.
    if (state_q == FCL_BUSY && mc_done) begin
      state_d = FCL_IDLE;
      arr_d   = mc_results.words;
    end
    if (state_q == FCL_BUSY && mc_protection_violation) begin
      pviol_d = 1'b1;
    end

    if (rd_en) begin
      unique case (paddr)
        OFS_TIME_BASE_DIVIDER: rdata_d = divider_word;
        OFS_CONTROLLER_STATUS: rdata_d = status_word;
        OFS_PARAMETER_INDEX:   rdata_d = {29'h00000000, index_q};
        OFS_PARAMETER_ARRAY:   rdata_d = {16'h0000, cur_word};
        OFS_PROGRAM_PROTECT:   rdata_d = {24'h000000, pprot_q};
        OFS_DATA_PROTECT:      rdata_d = {24'h000000, dprot_q};
        OFS_VERSION_ID:        rdata_d = {16'h0000, version_word};
        default:               rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= FCL_IDLE;
      div_q     <= '0;
      div_ld_q  <= 1'b0;
      access_error_flag_q  <= 1'b0;
      pviol_q   <= 1'b0;
      index_q   <= '0;
      pprot_q   <= PROTECT_RESET;
      dprot_q   <= PROTECT_RESET;
      arr_q     <= '0;
      launch_q  <= 1'b0;
      lparams_q <= '0;
      rdata_q   <= 32'h00000000;
    end else begin
      state_q   <= state_d;
      div_q     <= div_d;
      div_ld_q  <= div_ld_d;
      access_error_flag_q  <= access_error_flag_d;
      pviol_q   <= pviol_d;
      index_q   <= index_d;
      pprot_q   <= pprot_d;
      dprot_q   <= dprot_d;
      arr_q     <= arr_d;
      launch_q  <= launch_d;
      lparams_q <= lparams_d;
      rdata_q   <= rdata_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata              = rdata_q;
  assign pready              = 1'b1;
  assign pslverr             = psel && penable && !mapped;
  assign launch_pulse        = launch_q;
  assign launch_params       = lparams_q;
  assign divider_value_field = div_q;

endmodule

/* File: verif/fcl_top_properties.sv */
// Purpose: Port checks for the flash command launch front end.
// Assumes: Zero-wait APB slave; done pulses arrive only while a command runs.
// Notes:   Bound into every fcl_top instance.
`timescale 1ns/10ps
module fcl_top_properties #(
  parameter logic [3:0] VERSION_NUMBER = 4'h3
) (
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 launch_pulse,
  input wire fcl_pkg::fcl_params_t launch_params,
  input wire logic [6:0]           divider_value_field,
  input wire logic                 mc_done
);
  import fcl_pkg::*;
  // ****************
  // Helper state and properties
  // ****************
  logic acc;
  logic busy_q;
  logic busy_d;
  logic go_q;
  logic go_d;
  logic div_wr_q;
  logic div_wr_d;
  assign acc = psel && penable;
  // Busy runs from a launch pulse until the back end reports done.
  always_comb begin
    busy_d = busy_q;
    if (launch_pulse) begin
      busy_d = 1'b1;
    end else if (mc_done) begin
      busy_d = 1'b0;
    end
    go_d = acc && pwrite && paddr == OFS_CONTROLLER_STATUS && pwdata[7];
    div_wr_d = acc && pwrite && paddr == OFS_TIME_BASE_DIVIDER;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      go_q <= 1'b0;
      div_wr_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      go_q <= go_d;
      div_wr_q <= div_wr_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_ready_no_wait: assert property (acc |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_error: assert property (acc && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > 8'h1c)) else $error("pslverr does not match the map");
  chk_launch_cause: assert property (launch_pulse |-> go_q)
    else $error("launch without a launch write");
  chk_launch_single: assert property (launch_pulse |=> !launch_pulse)
    else $error("launch pulse too long");
  chk_no_relaunch: assert property (launch_pulse |-> !busy_q)
    else $error("launch while a command is active");
  chk_params_held: assert property (!launch_pulse |-> $stable(launch_params))
    else $error("launch parameters changed without a launch");
  chk_divider_cause: assert property ($changed(divider_value_field) |-> div_wr_q)
    else $error("divider changed without a write");
  chk_reserved_zero: assert property (acc && !pwrite && paddr == OFS_FACTORY_RESERVED7
    |-> prdata == 32'h0) else $error("reserved register not zero");
  chk_version_field: assert property (acc && !pwrite && paddr == OFS_VERSION_ID
    |-> prdata[3:0] == VERSION_NUMBER) else $error("version field wrong");
  cover property (launch_pulse);
  cover property (busy_q && mc_done);
  cover property (acc && pslverr);
endmodule

bind fcl_top fcl_top_properties #(.VERSION_NUMBER(VERSION_NUMBER)) fcl_top_properties_i (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .launch_pulse(launch_pulse), .launch_params(launch_params),
  .divider_value_field(divider_value_field), .mc_done(mc_done));

/* File: verif/fcl_top_tb.sv */
// Purpose: Self-checking bench for the flash command launch front end.
// Assumes: Zero-wait APB slave; the bench plays the memory controller.
// Notes:   Drivers queue expected reads and launch codes for the monitor.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module fcl_top_tb;
  import fcl_pkg::*;
  // ****************
  // Stimulus, monitor and scenarios
  // ****************
  localparam logic [3:0] VER = 4'h9;  // Arbitrary value.
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        spec = 1'b0;
  logic        secd = 1'b0;
  logic        launch_pulse;
  fcl_params_t launch_params;
  logic [6:0]  div;
  logic        mc_done = 1'b0;
  logic        mc_pviol = 1'b0;
  logic [3:0]  strb = 4'hf;
  fcl_params_t mc_results = '0;
  fcl_params_t res;
  logic [32:0] exp_q[$];
  logic [7:0]  code_q[$];
  logic [7:0]  codes[18] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
                            8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h05, 8'h0f};
  logic [7:0]  lc;
  logic [32:0] x;
  logic [31:0] rv;
  int          err_count = 0;
  int          total_checks = 0;

  fcl_top #(.VERSION_NUMBER(VER)) fcl_top_i (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_mode_input(spec), .secured_input(secd),
    .launch_pulse(launch_pulse), .launch_params(launch_params), .divider_value_field(div),
    .mc_done(mc_done), .mc_protection_violation(mc_pviol), .mc_results(mc_results));

  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #2000000;
    err_count++;
    end_sim();
  end
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      x = exp_q.pop_front();
      `CHK({pslverr, prdata[15:0] & x[15:0]}, x[32:16])
    end
    if (launch_pulse === 1'b1) begin
      lc = (code_q.size() != 0) ? code_q.pop_front() : 8'hxx;
      `CHK(launch_params.words[0][15:8], lc)
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m,
                    input logic se = 1'b0);
    exp_q.push_back({se, e, m});
    apb(1'b0, a, 16'h0);
  endtask
  task automatic mode(input logic sp, input logic sec);
    @(posedge clk);
    spec <= sp;
    secd <= sec;
    repeat (8) @(posedge clk);
  endtask
  function automatic logic legal(input logic sp, input logic sec, input logic [7:0] c);
    if (sp && sec) return c inside {8'h01, 8'h02, 8'h08, 8'h0b};
    if (sp) return c != 8'h0c;
    return !(c inside {8'h08, 8'h0b, 8'h0e});
  endfunction
  // Loads a code, launches it and expects status st; a run command is then completed.
  task automatic launch(input logic [7:0] c, input logic [7:0] st, input logic poke);
    apb(1'b1, OFS_PARAMETER_INDEX, 16'h0);
    apb(1'b1, OFS_PARAMETER_ARRAY, {c, 8'h00});
    if (st == 8'h00) code_q.push_back(c);
    apb(1'b1, OFS_CONTROLLER_STATUS, 16'h80);
    rd(OFS_CONTROLLER_STATUS, {8'h0, st}, 16'hb0);
    if (st != 8'h00) begin
      apb(1'b1, OFS_CONTROLLER_STATUS, 16'h30);
    end else begin
      if (poke) begin
        apb(1'b1, OFS_PARAMETER_ARRAY, 16'hbeef);
        apb(1'b1, OFS_CONTROLLER_STATUS, 16'h80);
        rd(OFS_PARAMETER_ARRAY, {c, 8'h00}, 16'hffff);
      end
      res = {$urandom, $urandom, $urandom};
      @(posedge clk);
      mc_results <= res;
      mc_done <= 1'b1;
      @(posedge clk);
      mc_done <= 1'b0;
      rd(OFS_PARAMETER_ARRAY, res.words[0], 16'hffff);
    end
    rd(OFS_CONTROLLER_STATUS, 16'h80, 16'hb0);
  endtask

  initial begin
    rv = $urandom(77302);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_TIME_BASE_DIVIDER, 16'h0, 16'hff);
    rd(OFS_CONTROLLER_STATUS, 16'h80, 16'hb0);
    rd(OFS_PROGRAM_PROTECT, 16'hff, 16'hff);
    apb(1'b1, OFS_FACTORY_RESERVED7, 16'hff);
    rd(OFS_FACTORY_RESERVED7, 16'h0, 16'hffff);
    rd(OFS_VERSION_ID, {12'h0, VER}, 16'hf);
    rd(8'h20, 16'h0, 16'h0, 1'b1);
    launch(CMD_PROGRAM_PHRASE, 8'ha0, 1'b0);
    launch(CMD_ERASE_VERIFY_ALL, 8'h00, 1'b1);
    rv = $urandom;
    apb(1'b1, OFS_TIME_BASE_DIVIDER, {9'h0, rv[6:0]});
    rd(OFS_TIME_BASE_DIVIDER, {8'h0, 1'b1, rv[6:0]}, 16'hff);
    `CHK(div, rv[6:0])
    apb(1'b1, OFS_PARAMETER_INDEX, 16'h5);
    apb(1'b1, OFS_PARAMETER_ARRAY, rv[31:16]);
    rd(OFS_PARAMETER_ARRAY, rv[31:16], 16'hffff);
    apb(1'b1, OFS_PARAMETER_INDEX, 16'h6);
    apb(1'b1, OFS_PARAMETER_ARRAY, 16'hffff);
    rd(OFS_PARAMETER_ARRAY, 16'h0, 16'hffff);
    for (int m = 0; m < 4; m++) begin
      mode(m[1], m[0]);
      for (int i = 0; i < 18; i++) begin
        launch(codes[i], (i < 16 && legal(m[1], m[0], codes[i])) ? 8'h00 : 8'ha0, 1'b0);
      end
    end
    mode(1'b1, 1'b0);
    apb(1'b1, OFS_PROGRAM_PROTECT, 16'hdf);
    launch(CMD_ERASE_ALL, 8'h90, 1'b0);
    launch(CMD_ERASE_BLOCK, 8'h90, 1'b0);
    apb(1'b1, OFS_PROGRAM_PROTECT, 16'hff);
    apb(1'b1, OFS_DATA_PROTECT, 16'h7f);
    launch(CMD_ERASE_ALL, 8'h90, 1'b0);
    launch(CMD_ERASE_BLOCK, 8'h00, 1'b0);
    rd(OFS_DATA_PROTECT, 16'h7f, 16'hff);
    mode(1'b0, 1'b0);
    apb(1'b1, OFS_PROGRAM_PROTECT, 16'h3c);
    apb(1'b1, OFS_PROGRAM_PROTECT, 16'hff);
    rd(OFS_PROGRAM_PROTECT, 16'h3c, 16'hff);
    apb(1'b1, OFS_PARAMETER_ARRAY, {CMD_ERASE_VERIFY_ALL, 8'h00});
    strb <= 4'h1;
    apb(1'b1, OFS_PARAMETER_ARRAY, 16'h5a5a);
    strb <= 4'hf;
    rd(OFS_PARAMETER_ARRAY, {CMD_ERASE_VERIFY_ALL, 8'h5a}, 16'hffff);
    code_q.push_back(CMD_ERASE_VERIFY_ALL);
    apb(1'b1, OFS_CONTROLLER_STATUS, 16'h80);
    apb(1'b1, OFS_TIME_BASE_DIVIDER, {9'h0, ~rv[6:0]});
    @(posedge clk);
    mc_pviol <= 1'b1;
    mc_done <= 1'b1;
    @(posedge clk);
    mc_pviol <= 1'b0;
    mc_done <= 1'b0;
    rd(OFS_CONTROLLER_STATUS, 16'h90, 16'hb0);
    rd(OFS_TIME_BASE_DIVIDER, {8'h0, 1'b1, rv[6:0]}, 16'hff);
    repeat (4) @(posedge clk);
    `CHK(code_q.size(), 0)
    end_sim();
  end
endmodule
